// *** inc/gpio_be_pkg.sv ***
package gpio_be_pkg;
  localparam logic [7:0] CPU_STATUS_ADDR     = 8'h06;
  localparam logic [7:0] CORE_INT_STATUS_ADDR = 8'h07;
  localparam logic [7:0] PORT_A_DATA_ADDR    = 8'h10;
  localparam logic [7:0] B_DIRECTION_ADDR    = 8'h11;
  localparam logic [7:0] B_DATA_LATCH_ADDR   = 8'h12;
  localparam logic [7:0] PERIPH_FLAGS_ADDR   = 8'h16;
  localparam logic [7:0] PERIPH_ENABLES_ADDR = 8'h17;
  localparam logic [7:0] E_DATA_LATCH_ADDR   = 8'h15;
  localparam logic [7:0] E_DIRECTION_ADDR    = 8'h14;
  localparam logic [3:0] BANK_B              = 4'h0;
  localparam logic [3:0] BANK_E              = 4'h1;
  localparam logic [7:0] B_DIRECTION_RESET   = 8'hFF;
  localparam logic [7:0] E_DIRECTION_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET         = 8'h00;
  localparam logic [7:0] B_PIN_IDLE          = 8'hFF;
  localparam logic [2:0] E_PIN_IDLE          = 3'h0;
  localparam logic [7:0] PERIPH_FLAGS_RESET  = 8'h02;
  localparam logic [7:0] PERIPH_ENABLES_RESET = 8'h00;
  localparam int         CHANGE_BIT          = 7;
  localparam int         E_WIDTH             = 3;
  localparam logic [1:0] MODE_MICROPROC      = 2'h0;
  localparam logic [1:0] MODE_EXT_MICRO      = 2'h1;
  localparam logic [1:0] MODE_MICRO          = 2'h2;
  localparam logic [1:0] MODE_PROT_MICRO     = 2'h3;
endpackage

// *** verification/gpio_be_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_be_chk
  import gpio_be_pkg::*;
(
  // watched ports
  input wire logic       clk, rstn, reg_wr, reg_rd, reg_hit, pullup_disable,
  input wire logic       pwm_out_one, pwm_one_on, b_change_irq, bus_active,
  input wire logic       bus_addr_latch, bus_out_enable_n, bus_write_n,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, b_pin_out, b_pin_oe, b_pullup_en,
  input wire logic [3:0] bank_select,
  input wire logic [1:0] proc_mode,
  input wire logic [2:0] e_pin_out, e_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire wb = reg_wr && bank_select == BANK_B;
  wire we = reg_wr && bank_select == BANK_E;
  a_bus_mode: assert property (bus_active == (proc_mode < MODE_MICRO))
    else $error("bus mode wrong");
  a_bus_strobes: assert property (bus_active |-> e_pin_oe == 3'h7 &&
    e_pin_out == {bus_write_n, bus_out_enable_n, bus_addr_latch}) else $error("strobes wrong");
  a_e_direction: assert property (we && reg_addr == E_DIRECTION_ADDR |=>
    bus_active || e_pin_oe == ~$past(reg_wdata[2:0])) else $error("e enable wrong");
  a_b_direction: assert property (wb && reg_addr == B_DIRECTION_ADDR |=>
    (b_pin_oe | 8'h0C) == (~$past(reg_wdata) | 8'h0C)) else $error("b enable wrong");
  a_pull_up: assert property ((b_pullup_en & 8'hF3) ==
    (~b_pin_oe & {8{!pullup_disable}} & 8'hF3)) else $error("pull-up wrong");
  a_pwm_drive: assert property (pwm_one_on |-> b_pin_oe[2] && b_pin_out[2] == pwm_out_one)
    else $error("pwm drive wrong");
  a_irq_gate: assert property (we && reg_addr == PERIPH_ENABLES_ADDR && !reg_wdata[7]
    |=> !b_change_irq) else $error("irq not gated");
  a_e_upper_zero: assert property (reg_rd && bank_select == BANK_E &&
    (reg_addr == E_DATA_LATCH_ADDR || reg_addr == E_DIRECTION_ADDR)
    |=> reg_hit && reg_rdata[7:3] == 5'h00) else $error("upper bits set");
endmodule
bind gpio_be gpio_be_chk chk_i (.*);
`default_nettype wire

// *** verification/pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_model #(parameter int W = 8) (
  // design side
  input  wire logic         clk,
  input  wire logic [W-1:0] out, oe, pull,
  // far side drivers
  input  wire logic [W-1:0] drv, val,
  output logic      [W-1:0] pin
);
  logic [W-1:0] last_r;
  // a floating line shows the inverse of its last level
  always_comb
    for (int i = 0; i < W; i++)
      pin[i] = oe[i] ? out[i] : drv[i] ? val[i] : pull[i] ? 1'b1 : ~last_r[i];
  always_ff @(posedge clk) last_r <= pin;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpio_be_pkg::*;
  logic       clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, pullup_disable = 0;
  logic       pwm_out_one = 0, pwm_out_two = 0, pwm_one_on = 0, pwm_two_on = 0;
  logic       bus_addr_latch = 0, bus_out_enable_n = 1, bus_write_n = 1;
  logic [7:0] reg_addr = '0, reg_wdata = '0, b_drv = '0, b_val = '0;
  logic [3:0] bank_select = '0;
  logic [1:0] proc_mode = MODE_MICRO;
  logic [2:0] e_val = '0;
  logic [7:0] reg_rdata, b_pin_in, b_pin_out, b_pin_oe, b_pullup_en;
  logic       reg_hit, capture_in_one, capture_in_two, timer_one_two_ext_clock;
  logic       timer_three_ext_clock, b_change_irq, bus_active;
  logic [2:0] e_pin_in, e_pin_out, e_pin_oe;
  int         bad_count = 0, n_compared = 0;
  // write flag, bank, address, data, expected read
  logic [31:0] rows [10] = '{32'h00_11_00_FF, 32'h01_16_00_02, 32'h01_17_00_00,
    32'h01_14_00_07, 32'h80_11_CF_CF, 32'h81_17_5A_5A, 32'h81_14_FE_06,
    32'h81_15_FD_01, 32'h82_11_55_00, 32'h80_FF_12_00};
  gpio_be gpio_be_i (.*);
  pin_model #(.W(8)) b_pins_i (.clk, .out(b_pin_out), .oe(b_pin_oe), .pull(b_pullup_en),
    .drv(b_drv), .val(b_val), .pin(b_pin_in));
  pin_model #(.W(3)) e_pins_i (.clk, .out(e_pin_out), .oe(e_pin_oe), .pull(3'h0),
    .drv(3'h7), .val(e_val), .pin(e_pin_in));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] b, input logic [7:0] a, d);
    @(posedge clk);
    {reg_wr, reg_rd, bank_select, reg_addr, reg_wdata} <= {w, !w, b, a, d};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
  endtask
  task automatic wait_irq(input logic v);
    int n = 0;
    while (b_change_irq !== v) begin
      @(posedge clk);
      #1;
      if (++n > 20) begin
        chk({7'h00, b_change_irq}, {7'h00, v});
        results();
      end
    end
    n_compared++;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    chk(b_pin_oe, 8'h00);
    // software uses bank 0 for the first port and bank 1 for the second, and bank 2 once as a wrong bank
    foreach (rows[i]) begin
      if (rows[i][31]) begin
        acc(1, rows[i][27:24], rows[i][23:16], rows[i][15:8]);
        repeat (4) @(posedge clk);
      end
      acc(0, rows[i][27:24], rows[i][23:16], 8'h00);
      chk(reg_rdata, rows[i][7:0]);
    end
    acc(1, BANK_B, B_DATA_LATCH_ADDR, 8'h10);
    b_drv = 8'hCF;
    b_val = 8'h0A;
    repeat (6) @(posedge clk);
    acc(0, BANK_B, B_DATA_LATCH_ADDR, 8'h00);
    chk(reg_rdata, 8'h1A);
    chk(b_pin_oe, 8'h30);
    chk(b_pullup_en, 8'hCF);
    chk({4'h0, timer_three_ext_clock, timer_one_two_ext_clock, capture_in_two,
      capture_in_one}, 8'h06);
    acc(1, BANK_E, PERIPH_FLAGS_ADDR, 8'h00);
    acc(1, BANK_E, PERIPH_ENABLES_ADDR, 8'h80);
    wait_irq(0);
    acc(1, BANK_B, B_DATA_LATCH_ADDR, 8'h30);
    repeat (6) @(posedge clk);
    chk({7'h00, b_change_irq}, 8'h00);
    b_val = 8'h0B;
    wait_irq(1);
    acc(1, BANK_E, PERIPH_ENABLES_ADDR, 8'h00);
    chk({7'h00, b_change_irq}, 8'h00);
    acc(1, BANK_E, PERIPH_ENABLES_ADDR, 8'h80);
    wait_irq(1);
    acc(1, BANK_E, E_DIRECTION_ADDR, 8'h00);
    chk({e_pin_oe, e_pin_out}, 8'h3D);
    {bus_write_n, bus_out_enable_n, bus_addr_latch} = 3'h2;
    for (int m = 0; m < 4; m++) begin
      proc_mode = 2'(m);
      @(posedge clk);
      #1;
      chk({1'h0, bus_active, e_pin_oe, e_pin_out}, m < 2 ? 8'h7A : 8'h3D);
    end
    {pwm_one_on, pwm_out_one, pwm_two_on, pullup_disable} = 4'hF;
    #1;
    chk({4'h0, b_pin_oe[3], b_pin_out[3], b_pin_oe[2], b_pin_out[2]}, 8'h0B);
    chk(b_pullup_en & 8'hF3, 8'h00);
    {pwm_one_on, pwm_two_on} = 2'h0;
    rstn = 0;
    #1;
    chk(b_pin_oe, 8'h00);
    @(posedge clk);
    rstn <= 1;
    acc(0, BANK_B, B_DIRECTION_ADDR, 8'h00);
    chk(reg_rdata, 8'hFF);
    results();
  end
endmodule
`default_nettype wire

// *** verilog/gpio_be.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_be
  import gpio_be_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [3:0] bank_select,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // configuration
  input  wire logic [1:0] proc_mode,
  // first port pins
  input  wire logic [7:0] b_pin_in,
  output logic      [7:0] b_pin_out,
  output logic      [7:0] b_pin_oe,
  output logic      [7:0] b_pullup_en,
  input  wire logic       pullup_disable,
  // peripheral sharing on the first port
  input  wire logic       pwm_out_one,
  input  wire logic       pwm_out_two,
  input  wire logic       pwm_one_on,
  input  wire logic       pwm_two_on,
  output logic            capture_in_one,
  output logic            capture_in_two,
  output logic            timer_one_two_ext_clock,
  output logic            timer_three_ext_clock,
  output logic            b_change_irq,
  // second port pins
  input  wire logic [2:0] e_pin_in,
  output logic      [2:0] e_pin_out,
  output logic      [2:0] e_pin_oe,
  // system bus strobes
  input  wire logic       bus_addr_latch,
  input  wire logic       bus_out_enable_n,
  input  wire logic       bus_write_n,
  output logic            bus_active
);
  // synchroniser stages; stage one feeds only stage two
  logic [7:0] b_s1_r;
  logic [7:0] b_s2_r;
  logic [7:0] b_s3_r;
  logic [7:0] b_s1_nxt;
  logic [7:0] b_s2_nxt;
  logic [7:0] b_s3_nxt;
  logic [2:0] e_s1_r;
  logic [2:0] e_s2_r;
  logic [2:0] e_s3_r;
  logic [2:0] e_s1_nxt;
  logic [2:0] e_s2_nxt;
  logic [2:0] e_s3_nxt;
  // filtered pin levels and the last sample seen by the change detector
  logic [7:0] b_level_r;
  logic [7:0] b_level_nxt;
  logic [2:0] e_level_r;
  logic [2:0] e_level_nxt;
  logic [7:0] b_last_r;
  logic [7:0] b_last_nxt;
  // port registers
  logic [7:0] b_direction_r;
  logic [7:0] b_direction_nxt;
  logic [7:0] b_latch_r;
  logic [7:0] b_latch_nxt;
  logic [2:0] e_direction_r;
  logic [2:0] e_direction_nxt;
  logic [2:0] e_latch_r;
  logic [2:0] e_latch_nxt;
  // interrupt registers
  logic [7:0] periph_flags_r;
  logic [7:0] periph_flags_nxt;
  logic [7:0] periph_enables_r;
  logic [7:0] periph_enables_nxt;
  // read port
  logic [7:0] reg_rdata_r;
  logic [7:0] reg_rdata_nxt;
  logic       reg_hit_r;
  logic       reg_hit_nxt;
  // decode
  logic       in_bank_b;
  logic       in_bank_e;
  logic       wr_b_dir;
  logic       wr_b_latch;
  logic       wr_e_dir;
  logic       wr_e_latch;
  logic       wr_enables;
  logic       wr_flags;
  logic       b_changed;

  // a change counts once stages two and three agree, a Schmitt-like filter
  always_comb begin
    b_s1_nxt    = b_pin_in;
    b_s2_nxt    = b_s1_r;
    b_s3_nxt    = b_s2_r;
    b_level_nxt = b_level_r;
    for (int i = 0; i < 8; i++) begin
      if (b_s2_r[i] == b_s3_r[i]) begin
        b_level_nxt[i] = b_s3_r[i];
      end
    end
  end

  // reset to the pulled-up idle level so that release gives no false change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b_s1_r    <= B_PIN_IDLE;
      b_s2_r    <= B_PIN_IDLE;
      b_s3_r    <= B_PIN_IDLE;
      b_level_r <= B_PIN_IDLE;
    end else begin
      b_s1_r    <= b_s1_nxt;
      b_s2_r    <= b_s2_nxt;
      b_s3_r    <= b_s3_nxt;
      b_level_r <= b_level_nxt;
    end
  end

  always_comb begin
    e_s1_nxt    = e_pin_in;
    e_s2_nxt    = e_s1_r;
    e_s3_nxt    = e_s2_r;
    e_level_nxt = e_level_r;
    for (int i = 0; i < E_WIDTH; i++) begin
      if (e_s2_r[i] == e_s3_r[i]) begin
        e_level_nxt[i] = e_s3_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      e_s1_r    <= E_PIN_IDLE;
      e_s2_r    <= E_PIN_IDLE;
      e_s3_r    <= E_PIN_IDLE;
      e_level_r <= E_PIN_IDLE;
    end else begin
      e_s1_r    <= e_s1_nxt;
      e_s2_r    <= e_s2_nxt;
      e_s3_r    <= e_s3_nxt;
      e_level_r <= e_level_nxt;
    end
  end

  // bank selection is the caller's duty; a wrong bank is ignored
  always_comb begin
    in_bank_b  = (bank_select == BANK_B);
    in_bank_e  = (bank_select == BANK_E);
    wr_b_dir   = reg_wr && in_bank_b && (reg_addr == B_DIRECTION_ADDR);
    wr_b_latch = reg_wr && in_bank_b && (reg_addr == B_DATA_LATCH_ADDR);
    wr_e_dir   = reg_wr && in_bank_e && (reg_addr == E_DIRECTION_ADDR);
    wr_e_latch = reg_wr && in_bank_e && (reg_addr == E_DATA_LATCH_ADDR);
    wr_enables = reg_wr && in_bank_e && (reg_addr == PERIPH_ENABLES_ADDR);
    wr_flags   = reg_wr && in_bank_e && (reg_addr == PERIPH_FLAGS_ADDR);
  end

  // a latch keeps its value while its pin is an input
  always_comb begin
    b_direction_nxt = b_direction_r;
    b_latch_nxt     = b_latch_r;
    e_direction_nxt = e_direction_r;
    e_latch_nxt     = e_latch_r;
    if (wr_b_dir) begin
      b_direction_nxt = reg_wdata;
    end
    if (wr_b_latch) begin
      b_latch_nxt = reg_wdata;
    end
    if (wr_e_dir) begin
      e_direction_nxt = reg_wdata[E_WIDTH-1:0];
    end
    if (wr_e_latch) begin
      e_latch_nxt = reg_wdata[E_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b_direction_r <= B_DIRECTION_RESET;
      b_latch_r     <= LATCH_RESET;
      e_direction_r <= E_DIRECTION_RESET[E_WIDTH-1:0];
      e_latch_r     <= LATCH_RESET[E_WIDTH-1:0];
    end else begin
      b_direction_r <= b_direction_nxt;
      b_latch_r     <= b_latch_nxt;
      e_direction_r <= e_direction_nxt;
      e_latch_r     <= e_latch_nxt;
    end
  end

  // hardware sets the change flag, software clears it; a set wins a clear
  always_comb begin
    periph_enables_nxt = periph_enables_r;
    periph_flags_nxt   = periph_flags_r;
    b_last_nxt         = b_level_r;
    b_changed          = |((b_level_r ^ b_last_r) & b_direction_r);
    if (wr_enables) begin
      periph_enables_nxt = reg_wdata;
    end
    if (wr_flags) begin
      periph_flags_nxt = reg_wdata;
    end
    if (b_changed) begin
      periph_flags_nxt[CHANGE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_flags_r   <= PERIPH_FLAGS_RESET;
      periph_enables_r <= PERIPH_ENABLES_RESET;
      b_last_r         <= B_PIN_IDLE;
    end else begin
      periph_flags_r   <= periph_flags_nxt;
      periph_enables_r <= periph_enables_nxt;
      b_last_r         <= b_last_nxt;
    end
  end

  // read data holds until the next read; unmapped reads give zero and no hit
  always_comb begin
    reg_rdata_nxt = reg_rdata_r;
    reg_hit_nxt   = 1'b0;
    if (reg_rd) begin
      reg_hit_nxt   = 1'b1;
      reg_rdata_nxt = 8'h00;
      if (in_bank_b) begin
        case (reg_addr)
          B_DIRECTION_ADDR: begin
            reg_rdata_nxt = b_direction_r;
          end
          B_DATA_LATCH_ADDR: begin
            reg_rdata_nxt = b_level_r;
          end
          default: begin
            reg_hit_nxt = 1'b0;
          end
        endcase
      end else if (in_bank_e) begin
        case (reg_addr)
          E_DIRECTION_ADDR: begin
            reg_rdata_nxt = {5'h00, e_direction_r};
          end
          E_DATA_LATCH_ADDR: begin
            reg_rdata_nxt = {5'h00, e_level_r};
          end
          PERIPH_ENABLES_ADDR: begin
            reg_rdata_nxt = periph_enables_r;
          end
          PERIPH_FLAGS_ADDR: begin
            reg_rdata_nxt = periph_flags_r;
          end
          default: begin
            reg_hit_nxt = 1'b0;
          end
        endcase
      end else begin
        reg_hit_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= 8'h00;
      reg_hit_r   <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
      reg_hit_r   <= reg_hit_nxt;
    end
  end

  // pin drivers and peripheral sharing
  always_comb begin
    bus_active  = (proc_mode == MODE_MICROPROC) || (proc_mode == MODE_EXT_MICRO);
    b_pin_out   = b_latch_r;
    b_pin_oe    = ~b_direction_r;
    b_pullup_en = b_direction_r;
    if (pwm_one_on) begin
      b_pin_out[2] = pwm_out_one;
      b_pin_oe[2]  = 1'b1;
    end
    if (pwm_two_on) begin
      b_pin_out[3] = pwm_out_two;
      b_pin_oe[3]  = 1'b1;
    end
    if (pullup_disable) begin
      b_pullup_en = 8'h00;
    end
    capture_in_one          = b_level_r[0];
    capture_in_two          = b_level_r[1];
    timer_one_two_ext_clock = b_level_r[4];
    timer_three_ext_clock   = b_level_r[5];
    b_change_irq = periph_flags_r[CHANGE_BIT] & periph_enables_r[CHANGE_BIT];
    if (bus_active) begin
      e_pin_out = {bus_write_n, bus_out_enable_n, bus_addr_latch};
      e_pin_oe  = 3'h7;
    end else begin
      e_pin_out = e_latch_r;
      e_pin_oe  = ~e_direction_r;
    end
    reg_rdata = reg_rdata_r;
    reg_hit   = reg_hit_r;
  end
endmodule
`default_nettype wire
